// *** sfd_pkg.sv ***
package sfd_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  // Period of pclk in nanoseconds (10 MHz).
  localparam int CLK_NS = 100;
  // Current limit deglitch, 2.5 us.
  localparam int CURRENT_LIMIT_DG_NS = 2500;
  // Relative thermal deglitch, 2.5 us.
  localparam int REL_DG_NS = 2500;
  // Absolute thermal deglitch, 20 us.
  localparam int ABS_DG_NS = 20000;
  // Open load deglitch, 500 us.
  localparam int OL_DG_US = 500;
  // Brief off time after a fast trip, 1 us.
  localparam int TRIP_OFF_NS = 1000;
  // Wait before an automatic retry, 1000 us.
  localparam int RETRY_US = 1000;

  // Least times round up to whole cycles.
  localparam int CURRENT_LIMIT_DG_CYC = (CURRENT_LIMIT_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int REL_DG_CYC = (REL_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABS_DG_CYC = (ABS_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int OL_DG_CYC = (OL_DG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TRIP_OFF_CYC = (TRIP_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_CYC = (RETRY_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Width of the retry and trip down-counters.
  localparam int CNT_W = 16;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;

  // Control register: one bit that holds the channel off.
  localparam int CTRL_W = 1;
  localparam int CTRL_FORCE_OFF = 0;
  localparam logic [0:0] CTRL_RESET = 1'h0;

  // Event bits, shared by interrupt status and mask.
  localparam int EV_W = 6;
  localparam int EV_OC = 0;
  localparam int EV_REL = 1;
  localparam int EV_ABS = 2;
  localparam int EV_OL = 3;
  localparam int EV_TRIP = 4;
  localparam int EV_LATCH = 5;
  localparam logic [5:0] MASK_RESET = 6'h00;

  // Live status word width.
  localparam int STAT_W = 12;

  // Number of pin inputs passed through the synchroniser.
  localparam int SYNC_W = 11;

  // ------------------------------------------------------------------
  // Channel states
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    SFD_OFF = 5'h01,
    SFD_ON = 5'h02,
    SFD_TRIP = 5'h04,
    SFD_SHUT = 5'h08,
    SFD_LATCHED = 5'h10
  } sfd_state_t;

endpackage

// *** sfd_sync.sv ***
`timescale 1ns/100ps
module sfd_sync
  import sfd_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, clean levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta;

  // ------------------------------------------------------------------
  // Two flip-flop chain
  // ------------------------------------------------------------------
  // Two stages give a metastable first stage a full cycle to settle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// *** sfd_deglitch.sv ***
`timescale 1ns/100ps
module sfd_deglitch
  import sfd_pkg::*;
#(
  parameter int CYCLES = 1
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw fault condition, already synchronised.
  input wire logic cond,
  // High once the condition has held CYCLES cycles in a row.
  output logic hit
);

  // Counter width large enough to hold CYCLES.
  localparam int W = $clog2(CYCLES + 1);
  // Saturation value of the counter.
  localparam logic [W-1:0] TOP = W'(CYCLES);

  // Cycles for which the condition has held so far.
  logic [W-1:0] count;
  // The counter has reached the full deglitch time.
  logic at_top;

  assign at_top = (count == TOP);
  // Gating with cond drops the hit in the same cycle the fault goes away.
  assign hit = at_top & cond;

  // ------------------------------------------------------------------
  // Persistence counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
    end
    else if (!cond)
    begin
      count <= '0;
    end
    else if (!at_top)
    begin
      count <= count + 1'b1;
    end
  end

endmodule

// *** sfd_switch_ctrl.sv ***
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
// How it works
// - diag low floats sense and fault flag
// - protection runs regardless of diag enable
// - overcurrent clamps current, reports fault
// - latch low retries after cooling, retry wait
// - latch high stays off until toggled
// - off-state open load pulls fault low
// - open-load fault clears when condition clears
// - deglitch 2.5, 2.5, 20, 500 us
// - short: regulate, trip, wait, re-enable
// - fast trip: brief off, then clamped on
// - pullup switch closed only with diag
// - short to supply handled as open load
// - reverse polarity forces channel on
// - after latch, enable restarts channel normally
// - absolute shutdown waits cooling and retry
module sfd_switch_ctrl
  import sfd_pkg::*;
#(
  parameter int OL_DEGLITCH_CYCLES = OL_DG_CYC,
  parameter int RETRY_CYCLES = RETRY_CYC
)
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host control pins.
  input wire logic channel_enable,
  input wire logic diagnostic_enable,
  input wire logic latch_select,
  // Comparator and sensor levels from the analog side.
  input wire logic overcurrent_detect,
  input wire logic fast_trip_threshold,
  input wire logic relative_thermal_trip,
  input wire logic absolute_thermal_trip,
  input wire logic thermal_cooled,
  input wire logic open_load_threshold,
  input wire logic reverse_polarity,
  // Power stage control.
  output logic channel_drive,
  output logic current_clamp,
  output logic pullup_switch,
  // Open-drain fault flag pin.
  input wire logic fault_flag_output_in,
  output logic fault_flag_output_out,
  output logic fault_flag_output_oe,
  // Sense output pin control.
  output logic sense_fault_level,
  output logic sense_output_oe,
  // Interrupt.
  output logic irq
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  // Raw pins gathered for the synchroniser.
  logic [SYNC_W-1:0] pins_raw;
  // Synchronised copy.
  logic [SYNC_W-1:0] pins_s;
  // Individual synchronised levels.
  logic en_s;
  logic diag_s;
  logic latch_s;
  logic oc_s;
  logic fast_s;
  logic rel_s;
  logic abs_s;
  logic cooled_s;
  logic ol_s;
  logic rev_s;
  logic flag_s;

  assign pins_raw = {fault_flag_output_in, reverse_polarity,
                     open_load_threshold, thermal_cooled,
                     absolute_thermal_trip, relative_thermal_trip,
                     fast_trip_threshold, overcurrent_detect,
                     latch_select, diagnostic_enable, channel_enable};
  assign {flag_s, rev_s, ol_s, cooled_s, abs_s, rel_s, fast_s, oc_s,
          latch_s, diag_s, en_s} = pins_s;

  sfd_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // ------------------------------------------------------------------
  // Fault deglitch filters
  // ------------------------------------------------------------------
  // Deglitched fault levels.
  logic oc_q;
  logic rel_q;
  logic abs_q;
  logic ol_q;
  // Open-load condition; only meaningful with the channel off.
  logic ol_cond;
  // Present channel state.
  sfd_state_t state;

  // same path for supply short
  // The pullup only exists with diag high, so detection needs it too.
  assign ol_cond = ol_s & diag_s & (state == SFD_OFF) & ~rev_s;

  sfd_deglitch #(
    .CYCLES(CURRENT_LIMIT_DG_CYC)
  ) u_dg_oc (
    .clk(pclk),
    .rst_n(presetn),
    .cond(oc_s),
    .hit(oc_q)
  );

  sfd_deglitch #(
    .CYCLES(REL_DG_CYC)
  ) u_dg_rel (
    .clk(pclk),
    .rst_n(presetn),
    .cond(rel_s),
    .hit(rel_q)
  );

  sfd_deglitch #(
    .CYCLES(ABS_DG_CYC)
  ) u_dg_abs (
    .clk(pclk),
    .rst_n(presetn),
    .cond(abs_s),
    .hit(abs_q)
  );

  sfd_deglitch #(
    .CYCLES(OL_DEGLITCH_CYCLES)
  ) u_dg_ol (
    .clk(pclk),
    .rst_n(presetn),
    .cond(ol_cond),
    .hit(ol_q)
  );

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Software control word.
  logic [CTRL_W-1:0] ctrl;
  // Sticky event bits and their mask.
  logic [EV_W-1:0] int_stat;
  logic [EV_W-1:0] int_mask;
  // Channel hold-off requested by software.
  logic force_off;

  assign force_off = ctrl[CTRL_FORCE_OFF];

  // ------------------------------------------------------------------
  // Channel state machine
  // ------------------------------------------------------------------
  // Down-counters for the retry wait and the fast-trip off time.
  logic [CNT_W-1:0] retry;
  logic [CNT_W-1:0] trip;
  // Last shutdown was an absolute thermal one.
  logic abs_flag;
  // Next values.
  sfd_state_t next_state;
  logic [CNT_W-1:0] next_retry;
  logic [CNT_W-1:0] next_trip;
  logic next_clamp;
  logic next_abs_flag;
  // Cooling condition met for the last shutdown kind.
  logic cool_ok;
  // Channel may start: enable high and software not holding it.
  logic start_ok;

  assign cool_ok = abs_flag ? cooled_s : ~rel_s;
  assign start_ok = en_s & ~force_off;

  // Diag enable is deliberately absent from every decision below.
  // protection ignores diag
  always_comb
  begin
    next_state = state;
    next_retry = retry;
    next_trip = trip;
    next_clamp = current_clamp;
    next_abs_flag = abs_flag;
    case (state)
      SFD_OFF:
      begin
        // A fresh start never inherits the clamp of a past fault.
        next_clamp = 1'b0;
        if (start_ok)
        begin
          next_state = SFD_ON;
        end
      end
      SFD_ON:
      begin
        if (!start_ok)
        begin
          next_state = SFD_OFF;
        end
        else if (rel_q || abs_q)
        begin
          next_state = SFD_SHUT;
          next_retry = CNT_W'(RETRY_CYCLES);
          next_abs_flag = abs_q;
          next_clamp = 1'b0;
        end
        else if (fast_s && !current_clamp)
        begin
          next_state = SFD_TRIP;
          next_trip = CNT_W'(TRIP_OFF_CYC);
        end
        else if (oc_q)
        begin
          next_clamp = 1'b1;
        end
      end
      SFD_TRIP:
      begin
        // Losing enable in the off time must not bring a drive pulse.
        if (!start_ok)
        begin
          next_state = SFD_OFF;
        end
        else if (trip == '0)
        begin
          next_state = SFD_ON;
          next_clamp = 1'b1;
        end
        else
        begin
          next_trip = trip - 1'b1;
        end
      end
      SFD_SHUT:
      begin
        if (retry != '0)
        begin
          next_retry = retry - 1'b1;
        end
        else if (cool_ok)
        begin
          if (latch_s)
          begin
            next_state = SFD_LATCHED;
          end
          else if (start_ok)
          begin
            next_state = SFD_ON;
          end
          else
          begin
            next_state = SFD_OFF;
          end
        end
      end
      SFD_LATCHED:
      begin
        // leave on latch or enable low
        if (!latch_s || !en_s)
        begin
          next_state = SFD_OFF;
        end
      end
      default:
      begin
        next_state = SFD_OFF;
      end
    endcase
  end

  // State and counters.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SFD_OFF;
      retry <= '0;
      trip <= '0;
      abs_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      retry <= next_retry;
      trip <= next_trip;
      abs_flag <= next_abs_flag;
    end
  end

  // ------------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------------
  // Any fault that the flag and sense pins should report.
  logic fault_now;
  // Channel gate request before the output flop.
  logic next_drive;

  assign fault_now = ((state == SFD_ON) & oc_q) | (state == SFD_TRIP)
                     | (state == SFD_SHUT) | (state == SFD_LATCHED)
                     | ol_q;
  assign next_drive = rev_s | (state == SFD_ON);

  // All pin outputs are registered so the pins never glitch.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_drive <= 1'b0;
      current_clamp <= 1'b0;
      pullup_switch <= 1'b0;
      fault_flag_output_out <= 1'b0;
      fault_flag_output_oe <= 1'b0;
      sense_fault_level <= 1'b0;
      sense_output_oe <= 1'b0;
    end
    else
    begin
      channel_drive <= next_drive;
      current_clamp <= next_clamp;
      pullup_switch <= diag_s;
      // The flag is open drain: it only ever pulls low.
      fault_flag_output_out <= 1'b0;
      fault_flag_output_oe <= diag_s & fault_now;
      sense_fault_level <= diag_s & fault_now;
      sense_output_oe <= diag_s;
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // Setup phase, completing access and completing write.
  logic setup;
  logic access;
  logic wr;
  // Address decode.
  logic hit_ctrl;
  logic hit_status;
  logic hit_stat;
  logic hit_mask;
  logic mapped;
  // Read mux result and live status word.
  logic [31:0] rdata;
  logic [STAT_W-1:0] status;
  // Event levels and write-one-to-clear bits.
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clr;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite & ~pslverr;
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_stat = (paddr == ADDR_INT_STAT);
  assign hit_mask = (paddr == ADDR_INT_MASK);
  assign mapped = hit_ctrl | hit_status | hit_stat | hit_mask;
  assign status = {fault_now, flag_s, rev_s, latch_s, en_s, diag_s,
                   current_clamp, state};
  assign rdata = hit_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl}
               : hit_status ? {{(32 - STAT_W){1'b0}}, status}
               : hit_stat ? {{(32 - EV_W){1'b0}}, int_stat}
               : hit_mask ? {{(32 - EV_W){1'b0}}, int_mask}
               : '0;

  // Events are levels; the sticky bits hold them after they pass.
  assign events[EV_OC] = (state == SFD_ON) & oc_q;
  assign events[EV_REL] = (state == SFD_SHUT) & ~abs_flag;
  assign events[EV_ABS] = (state == SFD_SHUT) & abs_flag;
  assign events[EV_OL] = ol_q;
  assign events[EV_TRIP] = (state == SFD_TRIP);
  assign events[EV_LATCH] = (state == SFD_LATCHED);
  assign clr = (wr && hit_stat) ? pwdata[EV_W-1:0] : '0;

  // One wait-free access: the answer is ready in the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rdata : '0;
    end
  end

  // Software registers; a pending event beats its own clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
      int_mask <= MASK_RESET;
      int_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl)
      begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (wr && hit_mask)
      begin
        int_mask <= pwdata[EV_W-1:0];
      end
      int_stat <= (int_stat & ~clr) | events;
      irq <= |(int_stat & int_mask);
    end
  end

endmodule

// *** sfd_host_model.sv ***
`timescale 1ns/100ps
module sfd_host_model
  import sfd_pkg::*;
(
  // Flag drivers.
  input wire logic fault_flag_output_out,
  input wire logic fault_flag_output_oe,
  // Sense drivers.
  input wire logic sense_fault_level,
  input wire logic sense_output_oe,
  // Pin levels seen by the host.
  output logic flag_wire,
  output logic sense_wire
);
  // The host pulls the open-drain flag line up when it is released.
  assign flag_wire = fault_flag_output_oe ? fault_flag_output_out : 1'h1;
  // host reads sense
  // A released sense line sinks to its pull-down level.
  assign sense_wire = sense_output_oe ? sense_fault_level : 1'h0;
endmodule

// *** sfd_switch_ctrl_assertions.sv ***
`timescale 1ns/100ps
module sfd_chk
  import sfd_pkg::*;
#(
  parameter int OL_DEGLITCH_CYCLES = OL_DG_CYC,
  parameter int RETRY_CYCLES = RETRY_CYC
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and sensed levels.
  input wire logic channel_enable,
  input wire logic diagnostic_enable,
  input wire logic open_load_threshold,
  input wire logic reverse_polarity,
  // Outputs under watch.
  input wire logic channel_drive,
  input wire logic pullup_switch,
  input wire logic fault_flag_output_out,
  input wire logic fault_flag_output_oe,
  input wire logic sense_fault_level,
  input wire logic sense_output_oe
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Open-load run length; it clears only after four low samples, so
  // a flag landing just after the level drops still sees its run.
  logic [15:0] ol_run;
  logic [3:0] ol_low;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ol_run <= 16'h0000;
      ol_low <= 4'h0;
    end
    else
    begin
      ol_low <= {ol_low[2:0], !open_load_threshold};
      if (open_load_threshold)
        ol_run <= ol_run + 16'h0001;
      else if (&ol_low)
        ol_run <= 16'h0000;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_FLOAT_SENSE: assert property (
    !diagnostic_enable [*4] |-> !sense_output_oe) else $error("sense on");
  AST_FLOAT_FLAG: assert property (
    !sense_output_oe |-> !fault_flag_output_oe) else $error("flag on");
  AST_PULLUP_OFF: assert property (
    !diagnostic_enable [*4] |-> !pullup_switch) else $error("pullup on");
  AST_PULLUP_ON: assert property (
    diagnostic_enable [*4] |-> pullup_switch) else $error("pullup off");
  AST_OPEN_DRAIN: assert property (
    fault_flag_output_out == 1'h0) else $error("flag driven high");
  AST_FAULT_PAIR: assert property (
    fault_flag_output_oe |-> sense_fault_level) else $error("sense low");
  AST_REVERSE_ON: assert property (
    reverse_polarity [*5] |-> channel_drive) else $error("not on");
  AST_OFF_IDLE: assert property (
    (!channel_enable && !reverse_polarity) [*5] |-> !channel_drive)
    else $error("drive without enable");
  AST_OL_DEGLITCH: assert property (
    $rose(fault_flag_output_oe) && $past(sense_output_oe) &&
    !$past(channel_drive) && !channel_drive
    |-> ol_run >= OL_DEGLITCH_CYCLES) else $error("early open load");
  AST_READY_PULSE: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("pready");
  AST_ERR_READY: assert property (
    pslverr |-> pready) else $error("pslverr alone");
  // Main scenarios.
  cover property ($rose(fault_flag_output_oe) && !channel_drive);
  cover property ($fell(channel_drive) && channel_enable);
  cover property (reverse_polarity && channel_drive);
  cover property (pslverr);
endmodule
bind sfd_switch_ctrl sfd_chk #(
  .OL_DEGLITCH_CYCLES(OL_DEGLITCH_CYCLES),
  .RETRY_CYCLES(RETRY_CYCLES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .channel_enable(channel_enable),
  .diagnostic_enable(diagnostic_enable),
  .open_load_threshold(open_load_threshold),
  .reverse_polarity(reverse_polarity), .channel_drive(channel_drive),
  .pullup_switch(pullup_switch),
  .fault_flag_output_out(fault_flag_output_out),
  .fault_flag_output_oe(fault_flag_output_oe),
  .sense_fault_level(sense_fault_level), .sense_output_oe(sense_output_oe)
);

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import sfd_pkg::*;
  // Short counts keep the run brief.
  localparam int OLC = 20;
  localparam int RTC = 30;
  // Bit of each host or analog level in pins.
  localparam int EN = 0, DG = 1, LT = 2, OC = 3, FT = 4;
  localparam int RL = 5, AB = 6, CO = 7, OL = 8, RV = 9;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] pins = 10'h000;
  logic [31:0] prdata;
  logic pready, pslverr, drv, clp, pu, fout, foe, sfl, soe, irq, fw, sw;
  // Error response taken at the edge that ends each transfer.
  logic last_err = 1'h0;
  int mismatches = 0;
  int n_compared = 0;
  always #50 pclk = ~pclk;
  sfd_switch_ctrl #(.OL_DEGLITCH_CYCLES(OLC), .RETRY_CYCLES(RTC)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_enable(pins[EN]),
    .diagnostic_enable(pins[DG]), .latch_select(pins[LT]),
    .overcurrent_detect(pins[OC]), .fast_trip_threshold(pins[FT]),
    .relative_thermal_trip(pins[RL]), .absolute_thermal_trip(pins[AB]),
    .thermal_cooled(pins[CO]), .open_load_threshold(pins[OL]),
    .reverse_polarity(pins[RV]), .channel_drive(drv), .current_clamp(clp),
    .pullup_switch(pu), .fault_flag_output_in(fw),
    .fault_flag_output_out(fout), .fault_flag_output_oe(foe),
    .sense_fault_level(sfl), .sense_output_oe(soe), .irq(irq));
  sfd_host_model u_host (.fault_flag_output_out(fout),
    .fault_flag_output_oe(foe), .sense_fault_level(sfl),
    .sense_output_oe(soe), .flag_wire(fw), .sense_wire(sw));
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic timeout_hit();
    check(32'h0, 32'h1);
    finish_test();
  endtask
  // One bus transfer; the request is held until pready is sampled.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
      if (k > 20)
        timeout_hit();
    end
    while (pready !== 1'h1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge pclk);
    pins[i] <= v;
  endtask
  function automatic logic pick(input int s);
    pick = (s == 0) ? drv : (s == 1) ? foe : clp;
  endfunction
  // Bounded wait for an output; n returns the cycles spent.
  task automatic wait_for(input int s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (pick(s) !== v)
    begin
      @(posedge pclk);
      n++;
      if (n > lim)
        timeout_hit();
    end
  endtask
  initial
  begin
    logic [31:0] q;
    int n;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, ADDR_CTRL, 32'h0, q);
    check(q, CTRL_RESET);
    apb(1'h0, ADDR_INT_MASK, 32'h0, q);
    check(q, MASK_RESET);
    apb(1'h0, ADDR_STATUS, 32'h0, q);
    check(q[4:0], SFD_OFF);
    apb(1'h0, 8'h10, 32'h0, q);
    check(last_err, 1'h1);
    check(q, 32'h0);
    $display("register test done");
    // Diagnostics off: both pins float, pullup open.
    pin(OL, 1'h1);
    repeat (OLC + 10) @(posedge pclk);
    check({soe, foe, fw}, 3'h1);
    check(pu, 1'h0);
    pin(OL, 1'h0);
    pin(DG, 1'h1);
    repeat (5) @(posedge pclk);
    check({pu, soe}, 2'h3);
    // A short pulse, a one-cycle gap, then a real open load.
    pin(OL, 1'h1);
    repeat (OLC / 2) @(posedge pclk);
    pin(OL, 1'h0);
    pin(OL, 1'h1);
    wait_for(1, 1'h1, OLC + 10, n);
    check(n >= OLC, 1'h1);
    check({fw, sfl}, 2'h1);
    apb(1'h0, ADDR_INT_STAT, 32'h0, q);
    check(q[EV_OL], 1'h1);
    apb(1'h1, ADDR_INT_MASK, 32'h1 << EV_OL, q);
    repeat (3) @(posedge pclk);
    check(irq, 1'h1);
    pin(OL, 1'h0);
    wait_for(1, 1'h0, 10, n);
    apb(1'h1, ADDR_INT_STAT, 32'h1 << EV_OL, q);
    repeat (3) @(posedge pclk);
    check(irq, 1'h0);
    $display("open load test done");
    pin(EN, 1'h1);
    wait_for(0, 1'h1, 10, n);
    check(clp, 1'h0);
    // Open load while on raises no flag; the host judges by sense.
    pin(OL, 1'h1);
    repeat (OLC + 5) @(posedge pclk);
    check({fw, sw}, 2'h2);
    pin(OL, 1'h0);
    // Software hold-off turns the channel off and back on.
    apb(1'h1, ADDR_CTRL, 32'h1 << CTRL_FORCE_OFF, q);
    wait_for(0, 1'h0, 10, n);
    apb(1'h0, ADDR_CTRL, 32'h0, q);
    check(q, 32'h1);
    apb(1'h1, ADDR_CTRL, 32'h0, q);
    wait_for(0, 1'h1, 10, n);
    check(clp, 1'h0);
    pin(FT, 1'h1);
    wait_for(0, 1'h0, 8, n);
    pin(FT, 1'h0);
    wait_for(0, 1'h1, TRIP_OFF_CYC + 10, n);
    check(n >= TRIP_OFF_CYC - 3, 1'h1);
    check(clp, 1'h1);
    pin(OC, 1'h1);
    wait_for(1, 1'h1, CURRENT_LIMIT_DG_CYC + 10, n);
    check(n >= CURRENT_LIMIT_DG_CYC, 1'h1);
    check({drv, sfl}, 2'h3);
    pin(OC, 1'h0);
    wait_for(1, 1'h0, 10, n);
    $display("overcurrent test done");
    pin(RL, 1'h1);
    wait_for(0, 1'h0, REL_DG_CYC + 10, n);
    check(n >= REL_DG_CYC, 1'h1);
    pin(RL, 1'h0);
    check(foe, 1'h1);
    wait_for(0, 1'h1, RTC + 20, n);
    check(n >= RTC - 2, 1'h1);
    pin(DG, 1'h0);
    pin(RL, 1'h1);
    wait_for(0, 1'h0, REL_DG_CYC + 10, n);
    check(foe, 1'h0);
    pin(RL, 1'h0);
    wait_for(0, 1'h1, RTC + 20, n);
    pin(DG, 1'h1);
    pin(AB, 1'h1);
    wait_for(0, 1'h0, ABS_DG_CYC + 10, n);
    check(n >= ABS_DG_CYC, 1'h1);
    pin(AB, 1'h0);
    repeat (RTC + 20) @(posedge pclk);
    check(drv, 1'h0);
    pin(CO, 1'h1);
    wait_for(0, 1'h1, 10, n);
    $display("thermal test done");
    // Latched off, released by the latch pin and then by enable.
    for (int i = 0; i < 2; i++)
    begin
      pin(LT, 1'h1);
      pin(RL, 1'h1);
      wait_for(0, 1'h0, REL_DG_CYC + 10, n);
      pin(RL, 1'h0);
      repeat (RTC + 20) @(posedge pclk);
      check(drv, 1'h0);
      apb(1'h0, ADDR_STATUS, 32'h0, q);
      check(q[4:0], SFD_LATCHED);
      pin(i == 0 ? LT : EN, 1'h0);
      pin(EN, 1'h1);
      wait_for(0, 1'h1, 10, n);
      pin(LT, 1'h0);
    end
    $display("latch test done");
    pin(EN, 1'h0);
    wait_for(0, 1'h0, 10, n);
    pin(RV, 1'h1);
    wait_for(0, 1'h1, 8, n);
    pin(RV, 1'h0);
    wait_for(0, 1'h0, 8, n);
    $display("reverse test done");
    finish_test();
  end
endmodule
